/* File: rtl/bfm_defs.vh */
/*
 * constants for the bridge fault monitor: register offsets, field
 * positions, reset values and timing figures.
 * assumes a 25 MHz pclk; included by bfm_top.v by bare name.
 */
`ifndef BFM_DEFS_VH
`define BFM_DEFS_VH

// ==========================================================
// register byte offsets
`define BFM_CFG_ADDR 12'h000
`define BFM_CODE_ADDR 12'h004
`define BFM_STATUS_ADDR 12'h008
`define BFM_CLEAR_ADDR 12'h00C
`define BFM_LIVE_ADDR 12'h010

// ==========================================================
// config fields
`define BFM_CFG_ESF 0
`define BFM_CFG_EWD 1
`define BFM_CFG_OCQ 2
`define BFM_CFG_AOL 3
`define BFM_CFG_DOO 4
`define BFM_CFG_OLI 5
`define BFM_CFG_WIDTH 6
`define BFM_CFG_RESET 6'h00

// code fields: offset, gain, oc threshold, ol threshold, oc time
`define BFM_CODE_WIDTH 19
`define BFM_CODE_RESET 19'h00000

// ==========================================================
// status bit positions
`define BFM_ST_AHU 0
`define BFM_ST_ALU 1
`define BFM_ST_BHU 2
`define BFM_ST_BLU 3
`define BFM_ST_VLO 4
`define BFM_ST_ETO 5
`define BFM_ST_OCA 6
`define BFM_ST_OCB 7
`define BFM_ST_OL 8
`define BFM_ST_WIDTH 9

// ==========================================================
// timing
`define BFM_CLK_NS 40
`define BFM_OCQ_STEP_NS 500
`define BFM_OLTO_MS 100
`define BFM_ETO_US 1000

`endif

/* File: rtl/bfm_top.v */
/*
 * bridge fault monitor: undervoltage, logic pin overvoltage, enable
 * watchdog, overcurrent qualifier and open-load timers, with an APB
 * register slave. comparators arrive asynchronously from analog.
 * assumes a 25 MHz pclk and an APB master that holds its request.
 *
 */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bfm_defs.vh"

module bfm_top #(
  parameter OLTO_CYC = (`BFM_OLTO_MS * 1000000) / `BFM_CLK_NS,
  parameter ETO_CYC = (`BFM_ETO_US * 1000) / `BFM_CLK_NS
) (
  input wire pclk, // bus clock
  input wire presetn, // async reset, active low
  input wire clk_en, // freezes all state when low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error
  input wire [3:0] gate_cmd, // gate requests {gla,gha,glb,ghb}
  input wire enable_pin, // enable input level
  input wire [3:0] gate_uv_cmp, // vgs undervoltage per gate
  input wire [6:0] logic_ov_cmp, // pin ov; bit 6 is diag pin
  input wire [1:0] oc_cmp, // overcurrent per phase {b,a}
  input wire ol_on_cmp, // sense below on-state threshold
  input wire ol_off_cmp, // node a above off threshold
  output reg gate_high_phase_a, // gate drive
  output reg gate_low_phase_a, // gate drive
  output reg gate_high_phase_b, // gate drive
  output reg gate_low_phase_b, // gate drive
  output reg fault_n, // general fault flag, active low
  output reg ol_sink_b_en, // test sink on bridge_node_b
  output reg ol_source_a_en, // test source on bridge_node_a
  output reg openload_current_select, // 1 selects 400 uA source
  output reg [3:0] overcurrent_threshold_code, // oc dac code
  output reg [3:0] openload_threshold_code, // ol dac code
  output reg [3:0] sense_amp_offset_code, // offset dac code
  output reg [2:0] sense_amp_gain_code // amplifier gain
);

  localparam OCQ_STEP = `BFM_OCQ_STEP_NS / `BFM_CLK_NS;
  localparam [7:0] OCQ_STEP8 = OCQ_STEP[7:0];

  // ==========================================================
  // registers
  reg [`BFM_CFG_WIDTH-1:0] cfg;
  reg [`BFM_CODE_WIDTH-1:0] code;
  reg [`BFM_ST_WIDTH-1:0] status;
  wire stop_on_fault_cfg = cfg[`BFM_CFG_ESF];
  wire enable_watchdog_cfg = cfg[`BFM_CFG_EWD];
  wire overcurrent_qualifier_mode = cfg[`BFM_CFG_OCQ];
  wire onstate_openload_enable = cfg[`BFM_CFG_AOL];
  wire offstate_openload_disable = cfg[`BFM_CFG_DOO];
  wire [3:0] overcurrent_qualify_time_code = code[18:15];

  // ==========================================================
  // input synchronisers
  reg [15:0] sync1;
  reg [15:0] sync2;
  wire [15:0] raw_in = {ol_off_cmp, ol_on_cmp, oc_cmp, logic_ov_cmp,
                        gate_uv_cmp, enable_pin};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end
    else if (clk_en)
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  wire en_s = sync2[0];
  wire [3:0] uv_s = sync2[4:1];
  wire [6:0] ov_s = sync2[11:5];
  wire [1:0] oc_s = sync2[13:12];
  wire olon_s = sync2[14];
  wire oloff_s = sync2[15];

  // ==========================================================
  // enable watchdog
  reg en_d;
  reg wd_armed;
  reg wd_to;
  reg [31:0] wd_cnt;
  wire en_edge = en_s ^ en_d;
  wire wd_expire = wd_armed && !wd_to && !en_edge &&
                   (wd_cnt >= ETO_CYC - 1);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_d <= 1'b0;
      wd_armed <= 1'b0;
      wd_to <= 1'b0;
      wd_cnt <= 32'h00000000;
    end
    else if (clk_en)
    begin
      en_d <= en_s;
      if (!enable_watchdog_cfg)
      begin
        wd_armed <= 1'b0;
        wd_to <= 1'b0;
        wd_cnt <= 32'h00000000;
      end
      else if (en_edge)
      begin
        wd_armed <= 1'b1;
        wd_to <= 1'b0;
        wd_cnt <= 32'h00000000;
      end
      else if (wd_expire)
        wd_to <= 1'b1;
      else if (wd_armed && !wd_to)
        wd_cnt <= wd_cnt + 32'h00000001;
    end
  end

  // gate permission: watchdog state or direct enable level
  wire drive_ok = enable_watchdog_cfg ? (wd_armed && !wd_to) : en_s;
  wire ov_inputs = |ov_s[5:0];
  wire ov_stop = ov_inputs && stop_on_fault_cfg;
  wire [3:0] gate_next = (drive_ok && !ov_stop) ? gate_cmd : 4'h0;
  wire [3:0] gate_now = {gate_low_phase_a, gate_high_phase_a,
                         gate_low_phase_b, gate_high_phase_b};

  // ==========================================================
  // overcurrent qualifier, one per phase
  // low sides: phase a is gate_now[3], phase b is gate_now[1]
  wire [1:0] low_on = {gate_now[1], gate_now[3]};
  reg [1:0] low_on_d;
  reg [1:0] oc_valid;
  wire [7:0] oc_limit = {4'h0, overcurrent_qualify_time_code} *
                        OCQ_STEP8;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_oc
      reg [7:0] cnt;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cnt <= 8'h00;
          oc_valid[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          oc_valid[gi] <= 1'b0;
          if (overcurrent_qualifier_mode)
          begin
            if (low_on[gi] && !low_on_d[gi])
              cnt <= 8'h00;
            else if (cnt < oc_limit)
              cnt <= cnt + 8'h01;
            if (oc_s[gi] && low_on[gi] && cnt >= oc_limit &&
                !(low_on[gi] && !low_on_d[gi]))
              oc_valid[gi] <= 1'b1;
          end
          else if (oc_s[gi] && low_on[gi])
          begin
            if (cnt >= oc_limit)
              oc_valid[gi] <= 1'b1;
            else
              cnt <= cnt + 8'h01;
          end
          else
            cnt <= 8'h00;
        end
      end
    end
  endgenerate

  // ==========================================================
  // open-load timers
  wire on_state = (gate_now[2] && gate_now[1]) ||
                  (gate_now[0] && gate_now[3]);
  wire on_run = onstate_openload_enable && on_state;
  wire off_state = (gate_now == 4'h0);
  wire off_run = !offstate_openload_disable && off_state;
  reg [31:0] ol_cnt;
  reg ol_active;
  wire ol_cond = (on_run && olon_s) || (off_run && oloff_s);
  wire ol_hit = ol_cond && !ol_active && (ol_cnt >= OLTO_CYC - 1);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ol_cnt <= 32'h00000000;
      ol_active <= 1'b0;
      low_on_d <= 2'b00;
    end
    else if (clk_en)
    begin
      low_on_d <= low_on;
      if (!ol_cond)
      begin
        ol_cnt <= 32'h00000000;
        ol_active <= 1'b0;
      end
      else if (ol_hit)
        ol_active <= 1'b1;
      else if (!ol_active)
        ol_cnt <= ol_cnt + 32'h00000001;
    end
  end

  // ==========================================================
  // sticky status: set wins over clear
  wire [3:0] uv_live = uv_s & gate_now; // active gates only
  wire [`BFM_ST_WIDTH-1:0] st_set = {ol_hit, oc_valid[1], oc_valid[0],
    wd_expire, |ov_s, uv_live[1], uv_live[0], uv_live[3], uv_live[2]};
  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire [`BFM_ST_WIDTH-1:0] st_clr =
    (wr_acc && paddr == `BFM_CLEAR_ADDR) ?
    pwdata[`BFM_ST_WIDTH-1:0] : {`BFM_ST_WIDTH{1'b0}};
  wire any_fault = (|uv_live) || (|ov_s) || wd_to || ol_active;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= {`BFM_ST_WIDTH{1'b0}};
      fault_n <= 1'b1;
      gate_high_phase_a <= 1'b0;
      gate_low_phase_a <= 1'b0;
      gate_high_phase_b <= 1'b0;
      gate_low_phase_b <= 1'b0;
      ol_sink_b_en <= 1'b0;
      ol_source_a_en <= 1'b0;
    end
    else if (clk_en)
    begin
      status <= (status & ~st_clr) | st_set;
      // oc never reaches the flag or the gates
      fault_n <= !any_fault;
      gate_low_phase_a <= gate_next[3];
      gate_high_phase_a <= gate_next[2];
      gate_low_phase_b <= gate_next[1];
      gate_high_phase_b <= gate_next[0];
      ol_sink_b_en <= off_run;
      ol_source_a_en <= off_run;
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  function [31:0] rd_mux;
    input [11:0] a;
    begin
      if (a == `BFM_CFG_ADDR)
        rd_mux = {26'h0000000, cfg};
      else if (a == `BFM_CODE_ADDR)
        rd_mux = {13'h0000, code};
      else if (a == `BFM_STATUS_ADDR)
        rd_mux = {23'h000000, status};
      else if (a == `BFM_LIVE_ADDR)
        rd_mux = {24'h000000, !fault_n, gate_now, wd_armed, wd_to,
                  ol_active};
      else
        rd_mux = 32'h00000000;
    end
  endfunction

  wire addr_ok = (paddr == `BFM_CFG_ADDR) || (paddr == `BFM_CODE_ADDR) ||
                 (paddr == `BFM_STATUS_ADDR) ||
                 (paddr == `BFM_CLEAR_ADDR) || (paddr == `BFM_LIVE_ADDR);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= `BFM_CFG_RESET;
      code <= `BFM_CODE_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      openload_current_select <= 1'b0;
      overcurrent_threshold_code <= 4'h0;
      openload_threshold_code <= 4'h0;
      sense_amp_offset_code <= 4'h0;
      sense_amp_gain_code <= 3'h0;
    end
    else if (clk_en)
    begin
      // ready and data rise in the setup cycle, seen in access
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux(paddr);
      if (wr_acc && paddr == `BFM_CFG_ADDR)
        cfg <= pwdata[`BFM_CFG_WIDTH-1:0];
      if (wr_acc && paddr == `BFM_CODE_ADDR)
        code <= pwdata[`BFM_CODE_WIDTH-1:0];
      openload_current_select <= cfg[`BFM_CFG_OLI];
      sense_amp_offset_code <= code[3:0];
      sense_amp_gain_code <= code[6:4];
      overcurrent_threshold_code <= code[10:7];
      openload_threshold_code <= code[14:11];
    end
  end

  wire unused_rd = rd_acc;

endmodule // bfm_top

`default_nettype wire

/* File: tb/bfm_checker.sv */
/* port-level assertions for bfm_top, bound to every instance.
   assumes the pclk domain only and zero-wait apb answers. */
`timescale 1ns/1ps
`default_nettype none
module bfm_checker (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [3:0] gate_cmd, // requested gates
  input wire logic [3:0] gate_uv_cmp, // gate undervoltage
  input wire logic [6:0] logic_ov_cmp, // pin overvoltage
  input wire logic gate_high_phase_a, // gate drive
  input wire logic gate_low_phase_a, // gate drive
  input wire logic gate_high_phase_b, // gate drive
  input wire logic gate_low_phase_b, // gate drive
  input wire logic fault_n, // general fault flag
  input wire logic ol_sink_b_en, // test sink
  input wire logic ol_source_a_en, // test source
  input wire logic [3:0] overcurrent_threshold_code // oc dac code
);
  logic [3:0] gv;
  assign gv = {gate_low_phase_a, gate_high_phase_a, gate_low_phase_b,
    gate_high_phase_b};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  // five samples cover the two-stage synchroniser plus the flag register
  sequence uv_held;
    (|(gate_uv_cmp & gv)) [*5];
  endsequence
  apb_ready_a: assert property (apb_setup |=> pready && penable)
    else $error("no ready after setup");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  uv_flag_a: assert property (uv_held |-> !fault_n)
    else $error("undervoltage without fault");
  ov_flag_a: assert property ((|logic_ov_cmp) [*5] |-> !fault_n)
    else $error("overvoltage without fault");
  gate_follow_a: assert property ((gv & ~$past(gate_cmd)) == 4'h0)
    else $error("gate driven unrequested");
  test_pair_a: assert property (ol_sink_b_en == ol_source_a_en)
    else $error("test sink and source differ");
  test_off_a: assert property ((gv != 4'h0) [*2] |-> !ol_source_a_en)
    else $error("test current with gates on");
  code_copy_a: assert property ($changed(overcurrent_threshold_code)
    |-> $past(psel && penable && pwrite, 2))
    else $error("threshold code moved without write");
endmodule // bfm_checker
bind bfm_top bfm_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .gate_cmd, .gate_uv_cmp, .logic_ov_cmp,
  .gate_high_phase_a, .gate_low_phase_a, .gate_high_phase_b,
  .gate_low_phase_b, .fault_n, .ol_sink_b_en, .ol_source_a_en,
  .overcurrent_threshold_code);
`default_nettype wire

/* File: tb/bfm_bridge_model.sv */
/* bridge, load and controller: enable toggling, sense and node a
   comparators. assumes gate vector order {gla,gha,glb,ghb}. */
`timescale 1ns/1ps
`default_nettype none
module bfm_bridge_model (
  input wire logic pclk, // bus clock
  input wire logic [3:0] gates, // gate outputs
  input wire logic source_a_en, // test source on node a
  input wire logic load_open, // load disconnected
  input wire logic wd_run, // controller alive
  output logic enable_pin, // enable level
  output logic ol_on_cmp, // sense below threshold
  output logic ol_off_cmp // node a above threshold
);
  logic [3:0] tick = 4'h0;
  initial enable_pin = 1'b1;
  always @(posedge pclk)
  begin
    tick <= tick + 4'h1;
    if (wd_run && tick == 4'hF)
      enable_pin <= ~enable_pin;
  end
  // sense reads zero outside the two diagonal states
  assign ol_on_cmp = !(!load_open && ((gates[2] && gates[1]) ||
    (gates[0] && gates[3])));
  // a driven phase a high side (gates[2]) pulls node a up as well
  assign ol_off_cmp = (source_a_en && load_open) || gates[2];
endmodule // bfm_bridge_model
`default_nettype wire

/* File: tb/tb_bridge_fault_monitor.sv */
/* self-checking bench for bfm_top over apb with the bridge model.
   assumes OLTO_CYC 50 and ETO_CYC 40 to keep the run short. */
`timescale 1ns/1ps
`default_nettype none
`include "bfm_defs.vh"
module tb_bridge_fault_monitor;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] gate_cmd, gate_uv_cmp, overcurrent_threshold_code;
  logic [3:0] openload_threshold_code, sense_amp_offset_code;
  logic [2:0] sense_amp_gain_code;
  logic [6:0] logic_ov_cmp;
  logic [1:0] oc_cmp;
  logic gate_high_phase_a, gate_low_phase_a, gate_high_phase_b;
  logic gate_low_phase_b, fault_n, ol_sink_b_en, ol_source_a_en;
  logic openload_current_select, enable_pin, ol_on_cmp, ol_off_cmp;
  logic load_open, wd_run;
  int err_total, num_checks, cycles;
  bfm_top #(.OLTO_CYC(50), .ETO_CYC(40)) DUT (.pclk, .presetn,
    .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gate_cmd, .enable_pin, .gate_uv_cmp,
    .logic_ov_cmp, .oc_cmp, .ol_on_cmp, .ol_off_cmp, .gate_high_phase_a,
    .gate_low_phase_a, .gate_high_phase_b, .gate_low_phase_b, .fault_n,
    .ol_sink_b_en, .ol_source_a_en, .openload_current_select,
    .overcurrent_threshold_code, .openload_threshold_code,
    .sense_amp_offset_code, .sense_amp_gain_code);
  bfm_bridge_model u_bridge (.pclk, .gates({gate_low_phase_a,
    gate_high_phase_a, gate_low_phase_b, gate_high_phase_b}),
    .source_a_en(ol_source_a_en), .load_open, .wd_run, .enable_pin,
    .ol_on_cmp, .ol_off_cmp);
  // ==========================================================
  // tasks
  task complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk_reg(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk(32'(rerr), 32'(a > 12'h010));
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ==========================================================
  // clock, timeout, scenarios
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      complete_run;
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rerr} = '0;
    {gate_cmd, gate_uv_cmp, logic_ov_cmp, oc_cmp, load_open, wd_run} = '0;
    {err_total, num_checks, cycles} = '0;
    cyc(4);
    presetn <= 1'b1;
    chk_reg(`BFM_CFG_ADDR, 32'h0);
    chk_reg(`BFM_STATUS_ADDR, 32'h0);
    chk_reg(12'h014, 32'h0);
    bus(1'b1, `BFM_CODE_ADDR, {13'h0, 4'h2, 4'hC, 4'h5, 3'h6, 4'hA});
    cyc(2);
    chk(32'(overcurrent_threshold_code), 32'h5);
    chk(32'(openload_threshold_code), 32'hC);
    chk(32'({sense_amp_gain_code, sense_amp_offset_code}), 32'h6A);
    gate_cmd <= 4'h1;
    gate_uv_cmp <= 4'h1;
    cyc(6);
    chk(32'(fault_n), 32'h0);
    chk(32'(gate_high_phase_b), 32'h1);
    gate_uv_cmp <= 4'h0;
    cyc(6);
    chk(32'(fault_n), 32'h1);
    chk_reg(`BFM_STATUS_ADDR, 32'h4);
    bus(1'b1, `BFM_CLEAR_ADDR, 32'h1FF);
    bus(1'b1, `BFM_CFG_ADDR, 32'h1);
    logic_ov_cmp <= 7'h40;
    cyc(6);
    chk(32'(fault_n), 32'h0);
    chk(32'(gate_high_phase_b), 32'h1);
    logic_ov_cmp <= 7'h01;
    cyc(6);
    chk(32'(gate_high_phase_b), 32'h0);
    logic_ov_cmp <= 7'h00;
    cyc(6);
    chk(32'({fault_n, gate_high_phase_b}), 32'h3);
    chk_reg(`BFM_STATUS_ADDR, 32'h10);
    bus(1'b1, `BFM_CLEAR_ADDR, 32'h1FF);
    // qualify code 2 is 24 cycles: a 20 cycle pulse must not count
    gate_cmd <= 4'h8;
    oc_cmp <= 2'h3;
    cyc(20);
    oc_cmp <= 2'h0;
    cyc(6);
    chk_reg(`BFM_STATUS_ADDR, 32'h0);
    oc_cmp <= 2'h3;
    cyc(32);
    oc_cmp <= 2'h0;
    chk(32'({fault_n, gate_low_phase_a}), 32'h3);
    chk_reg(`BFM_STATUS_ADDR, 32'h40);
    gate_cmd <= 4'h6;
    load_open <= 1'b1;
    cyc(60);
    chk(32'(fault_n), 32'h1);
    bus(1'b1, `BFM_CFG_ADDR, 32'h8);
    cyc(60);
    chk(32'(fault_n), 32'h0);
    load_open <= 1'b0;
    cyc(6);
    chk(32'(fault_n), 32'h1);
    chk_reg(`BFM_STATUS_ADDR, 32'h140);
    bus(1'b1, `BFM_CLEAR_ADDR, 32'h1FF);
    bus(1'b1, `BFM_CFG_ADDR, 32'h20);
    gate_cmd <= 4'h0;
    load_open <= 1'b1;
    cyc(4);
    chk(32'({ol_source_a_en, openload_current_select}), 32'h3);
    cyc(26);
    gate_cmd <= 4'h1;
    cyc(4);
    gate_cmd <= 4'h0;
    cyc(30);
    chk(32'(fault_n), 32'h1);
    cyc(30);
    chk(32'(fault_n), 32'h0);
    gate_cmd <= 4'h1;
    cyc(6);
    chk(32'({fault_n, ol_source_a_en}), 32'h2);
    chk_reg(`BFM_STATUS_ADDR, 32'h100);
    // blanking: comparator ignored for 24 cycles after low-side turn-on
    bus(1'b1, `BFM_CFG_ADDR, 32'h14);
    gate_cmd <= 4'h0;
    oc_cmp <= 2'h3;
    cyc(4);
    gate_cmd <= 4'h8;
    cyc(10);
    chk_reg(`BFM_STATUS_ADDR, 32'h100);
    cyc(30);
    chk_reg(`BFM_STATUS_ADDR, 32'h140);
    oc_cmp <= 2'h0;
    gate_cmd <= 4'h1;
    load_open <= 1'b0;
    bus(1'b1, `BFM_CLEAR_ADDR, 32'h1FF);
    bus(1'b1, `BFM_CFG_ADDR, 32'h2);
    cyc(4);
    chk(32'(gate_high_phase_b), 32'h0);
    wd_run <= 1'b1;
    cyc(100);
    chk(32'({fault_n, gate_high_phase_b}), 32'h3);
    wd_run <= 1'b0;
    cyc(60);
    chk(32'({fault_n, gate_high_phase_b}), 32'h0);
    wd_run <= 1'b1;
    cyc(24);
    chk(32'({fault_n, gate_high_phase_b}), 32'h3);
    chk_reg(`BFM_STATUS_ADDR, 32'h20);
    complete_run;
  end
endmodule // tb_bridge_fault_monitor
`default_nettype wire
